// ===== dpom_consts.svh
`ifndef DPOM_CONSTS_SVH
`define DPOM_CONSTS_SVH
// register offsets (byte-wide registers on a plain port)
`define DPOM_ADDR_OFFSET_LO 8'h00
`define DPOM_ADDR_OFFSET_HI 8'h01
`define DPOM_ADDR_CTRL 8'h02
`define DPOM_ADDR_MEAS_CTRL 8'h03
`define DPOM_ADDR_BW 8'h04
`define DPOM_ADDR_STATUS 8'h05
`define DPOM_ADDR_FREQ1 8'h06
`define DPOM_ADDR_FREQ2 8'h07
`define DPOM_ADDR_FREQ3 8'h08
`define DPOM_ADDR_PHASE1 8'h09
`define DPOM_ADDR_PHASE2 8'h0A
`define DPOM_ADDR_OFFSET_TOP 8'h0B
// control register fields
`define DPOM_CTRL_SWBO_BIT 0
`define DPOM_CTRL_MONBO_BIT 1
`define DPOM_CTRL_RECALIBRATE_REQUEST_BIT 2
// measurement control fields
`define DPOM_MC_SEL_BIT 0
`define DPOM_MC_CMP_BIT 1
`define DPOM_MC_FORCE_LSB 2
// offset span: 200 ns in 6 ps steps -> +/-33333 codes
`define DPOM_OFFSET_MAX_PS 200000
`define DPOM_OFFSET_STEP_PS 6
`define DPOM_OFFSET_MAX_CODE 17'sd33333
// frequency span: 80 ppm at 0.0003068 ppm per code
`define DPOM_MEASURED_FREQUENCY_MAX_CODE 24'sd260756
// bandwidth settings
`define DPOM_MAIN_BW_COUNT 5'd18
`define DPOM_AUX_BW_COUNT 2'd3
// ramp step of the offset, codes per tick
`define DPOM_RAMP_STEP 17'sd1
// divider reset hold time
`define DPOM_DIVRST_NS 200
`define DPOM_CLK_NS 40
`define DPOM_DIVRST_CYC ((`DPOM_DIVRST_NS + `DPOM_CLK_NS - 1) / `DPOM_CLK_NS)
// phase averaging shift, ~100 Hz corner at the measure rate
`define DPOM_PH_SHIFT 4
`define DPOM_RESET_BYTE 8'h00
`endif

// ===== dpom_meas_model.sv
`timescale 1ns/1ps
module dpom_meas_model
   import dpom_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic tick_en,
   output logic ramp_tick,
   output logic meas_valid,
   output dpom_meas_type main_meas,
   output dpom_meas_type aux_meas
);
   logic [1:0] div_q;
   // loop filter grants one offset step per cycle while enabled
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= 2'h0;
         ramp_tick <= 1'b0;
         meas_valid <= 1'b0;
      end else begin
         div_q <= div_q + 2'h1;
         ramp_tick <= tick_en;
         meas_valid <= (div_q == 2'h3);
      end
   end
   // both references share one rate, so an undivided compare is legal
   assign main_meas = '{measured_frequency: 24'h012345, phase: 16'h0400};
   assign aux_meas = '{measured_frequency: 24'hFEDCBA, phase: 16'hFC00};
endmodule

// ===== dpom_pkg.sv
package dpom_pkg;
   typedef enum logic [4:0] {
      DPOM_IDLE = 5'b00001,
      DPOM_RAMP0 = 5'b00010,
      DPOM_DIVRST = 5'b00100,
      DPOM_RAMPN = 5'b01000,
      DPOM_EXIT = 5'b10000
   } dpom_state_type;
   typedef enum logic [1:0] {
      DPOM_DIRECT = 2'd0,
      DPOM_LOCK_AT_EIGHT_KHZ = 2'd1,
      DPOM_DIVIDE_BY_N_LOCK = 2'd2
   } dpom_lock_type;
   typedef struct packed {
      logic [23:0] measured_frequency;
      logic [15:0] phase;
   } dpom_meas_type;
endpackage

// ===== dpom_top.sv
`timescale 1ns/1ps
`include "dpom_consts.svh"
// Operation
// - with both build-outs off, manual offset drives main pll phase offset
// - offset spans plus or minus 200 ns in 6 ps steps
// - offset enters feedback path and ramps, never steps
// - recalibrate bit starts a realignment of feedback synthesizer
// - holdover, ramp to zero, reset dividers, ramp to offset, leave holdover
// - offset written during recalibration becomes the final ramp target
// - input monitors report frequency at 3.8 ppm resolution
// - three-byte frequency field from main or aux, by select bit
// - frequency step 0.0003068 ppm, range plus or minus 80 ppm; first byte reads live value, unclamped
// - frequency field returns the pll integral path value
// - two-byte phase field from selected pll, averaged near 100 hz
// - main pll phase is reference against internal feedback
// - compare mode disables aux path, aux detector compares both references
// - aux force field picks any input as aux reference
// - in compare with aux divided, main copy divided, by n only when main divides by n, else 8 khz lock
// - main pll keeps locking to its own reference during compare
// - input declared invalid when wander frequency exceeds its limits
// - main bandwidth chosen among 18 settings
// - aux bandwidth chosen among exactly three settings
// - phase field in degrees, offset register in 6 ps steps
module dpom_top
   import dpom_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic ramp_tick,
   input wire logic meas_valid,
   input wire dpom_meas_type main_meas,
   input wire dpom_meas_type aux_meas,
   input wire logic [1:0] main_lock_mode,
   input wire logic [1:0] aux_lock_mode,
   input wire logic [3:0] input_measured_frequency_err,
   input wire logic [3:0] input_measured_frequency_limit,
   output logic signed [16:0] feedback_offset,
   output logic mini_holdover,
   output logic divider_reset,
   output logic recalibrate_request_busy,
   output logic aux_path_disable,
   output logic [3:0] aux_reference_force,
   output logic [1:0] main_copy_mode,
   output logic main_copy_enable,
   output logic [4:0] main_bw_sel,
   output logic [1:0] aux_bw_sel,
   output logic [3:0] input_invalid
);
   // 17 bits: +/-33333 codes do not fit a 16-bit signed word
   logic [16:0] offset_q;
   logic switch_buildout_enable;
   logic monitor_buildout_enable;
   logic measure_pll_select;
   logic reference_compare_enable;
   logic recalibrate_request_req;
   dpom_state_type state_q;
   logic [3:0] rst_cnt_q;
   logic signed [16:0] target;
   dpom_meas_type sel_meas;
   logic [23:0] measured_frequency_snap_q;
   logic [15:0] phase_avg_q;
   logic [15:0] phase_snap_q;
   logic signed [16:0] ph_diff;
   logic buildout_off;

   assign buildout_off = !switch_buildout_enable && !monitor_buildout_enable;

   // register writes
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         offset_q <= 17'h00000;
         switch_buildout_enable <= 1'b0;
         monitor_buildout_enable <= 1'b0;
         measure_pll_select <= 1'b0;
         reference_compare_enable <= 1'b0;
         aux_reference_force <= 4'h0;
         main_bw_sel <= 5'h00;
         aux_bw_sel <= 2'h0;
      end else if (wr_stb) begin
         unique case (addr)
            `DPOM_ADDR_OFFSET_LO: offset_q[7:0] <= wdata;
            `DPOM_ADDR_OFFSET_HI: offset_q[15:8] <= wdata;
            `DPOM_ADDR_OFFSET_TOP: offset_q[16] <= wdata[0];
            `DPOM_ADDR_CTRL: begin
               switch_buildout_enable <= wdata[`DPOM_CTRL_SWBO_BIT];
               monitor_buildout_enable <= wdata[`DPOM_CTRL_MONBO_BIT];
            end
            `DPOM_ADDR_MEAS_CTRL: begin
               measure_pll_select <= wdata[`DPOM_MC_SEL_BIT];
               reference_compare_enable <= wdata[`DPOM_MC_CMP_BIT];
               aux_reference_force <= wdata[`DPOM_MC_FORCE_LSB+:4];
            end
            `DPOM_ADDR_BW: begin
               if (wdata[4:0] < `DPOM_MAIN_BW_COUNT) begin
                  main_bw_sel <= wdata[4:0];
               end
               if (wdata[6:5] < `DPOM_AUX_BW_COUNT) begin
                  aux_bw_sel <= wdata[6:5];
               end
            end
            default: ;
         endcase
      end
   end

   assign recalibrate_request_req = wr_stb && addr == `DPOM_ADDR_CTRL &&
      wdata[`DPOM_CTRL_RECALIBRATE_REQUEST_BIT];

   // clamp offset to +/-200 ns
   always_comb begin
      if ($signed(offset_q) > `DPOM_OFFSET_MAX_CODE) begin
         target = `DPOM_OFFSET_MAX_CODE;
      end else if ($signed(offset_q) < -`DPOM_OFFSET_MAX_CODE) begin
         target = -`DPOM_OFFSET_MAX_CODE;
      end else begin
         target = $signed(offset_q);
      end
   end

   // recalibration sequence
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= DPOM_IDLE;
         rst_cnt_q <= 4'h0;
      end else begin
         unique case (state_q)
            DPOM_IDLE:
               if (recalibrate_request_req) begin
                  state_q <= DPOM_RAMP0;
               end
            DPOM_RAMP0:
               if (feedback_offset == 17'sd0) begin
                  state_q <= DPOM_DIVRST;
                  rst_cnt_q <= 4'(`DPOM_DIVRST_CYC);
               end
            DPOM_DIVRST: begin
               rst_cnt_q <= rst_cnt_q - 4'h1;
               if (rst_cnt_q == 4'h1) begin
                  state_q <= DPOM_RAMPN;
               end
            end
            DPOM_RAMPN:
               // target read live, so a late write retargets
               if (feedback_offset == target) begin
                  state_q <= DPOM_EXIT;
               end
            DPOM_EXIT: state_q <= DPOM_IDLE;
            default: state_q <= DPOM_IDLE;
         endcase
      end
   end

   assign mini_holdover = state_q != DPOM_IDLE;
   assign divider_reset = state_q == DPOM_DIVRST;
   assign recalibrate_request_busy = mini_holdover;

   // offset ramps one step per tick in the feedback path
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         feedback_offset <= 17'sd0;
      end else if (ramp_tick) begin
         if (state_q == DPOM_RAMP0 || state_q == DPOM_DIVRST ||
             (state_q == DPOM_IDLE && !buildout_off)) begin
            if (feedback_offset > 17'sd0) begin
               feedback_offset <= feedback_offset - `DPOM_RAMP_STEP;
            end else if (feedback_offset < 17'sd0) begin
               feedback_offset <= feedback_offset + `DPOM_RAMP_STEP;
            end
         end else if (feedback_offset < target) begin
            feedback_offset <= feedback_offset + `DPOM_RAMP_STEP;
         end else if (feedback_offset > target) begin
            feedback_offset <= feedback_offset - `DPOM_RAMP_STEP;
         end
      end
   end

   // compare mode routing
   assign aux_path_disable = reference_compare_enable;
   assign main_copy_enable = reference_compare_enable;
   always_comb begin
      if (aux_lock_mode == DPOM_DIRECT) begin
         main_copy_mode = DPOM_DIRECT;
      end else if (main_lock_mode == DPOM_DIVIDE_BY_N_LOCK) begin
         main_copy_mode = DPOM_DIVIDE_BY_N_LOCK;
      end else begin
         main_copy_mode = DPOM_LOCK_AT_EIGHT_KHZ;
      end
   end

   // input invalid on long-term frequency limit; input_measured_frequency_err carries
   // the verdicts of the 3.8 ppm input monitors
   assign input_invalid = input_measured_frequency_err & input_measured_frequency_limit;

   // measurement select and phase averaging
   assign sel_meas = measure_pll_select ? aux_meas : main_meas;
   assign ph_diff = $signed({sel_meas.phase[15], sel_meas.phase}) -
      $signed({phase_avg_q[15], phase_avg_q});

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_avg_q <= 16'h0000;
      end else if (meas_valid) begin
         phase_avg_q <= phase_avg_q +
            16'(ph_diff >>> `DPOM_PH_SHIFT);
      end
   end

   // snapshot taken on first byte read, held for the rest
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         measured_frequency_snap_q <= 24'h000000;
         phase_snap_q <= 16'h0000;
      end else if (rd_stb) begin
         if (addr == `DPOM_ADDR_FREQ1) begin
            if ($signed(sel_meas.measured_frequency) > `DPOM_MEASURED_FREQUENCY_MAX_CODE) begin
               measured_frequency_snap_q <= `DPOM_MEASURED_FREQUENCY_MAX_CODE;
            end else if ($signed(sel_meas.measured_frequency) < -`DPOM_MEASURED_FREQUENCY_MAX_CODE) begin
               measured_frequency_snap_q <= -`DPOM_MEASURED_FREQUENCY_MAX_CODE;
            end else begin
               measured_frequency_snap_q <= sel_meas.measured_frequency;
            end
         end
         if (addr == `DPOM_ADDR_PHASE1) begin
            phase_snap_q <= phase_avg_q;
         end
      end
   end

   // read data one cycle after strobe
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata <= `DPOM_RESET_BYTE;
      end else if (rd_stb) begin
         unique case (addr)
            `DPOM_ADDR_OFFSET_LO: rdata <= offset_q[7:0];
            `DPOM_ADDR_OFFSET_HI: rdata <= offset_q[15:8];
            `DPOM_ADDR_OFFSET_TOP: rdata <= {7'h00, offset_q[16]};
            `DPOM_ADDR_CTRL: rdata <= {6'h00, monitor_buildout_enable,
               switch_buildout_enable};
            `DPOM_ADDR_MEAS_CTRL: rdata <= {2'h0, aux_reference_force,
               reference_compare_enable, measure_pll_select};
            `DPOM_ADDR_BW: rdata <= {1'b0, aux_bw_sel, main_bw_sel};
            `DPOM_ADDR_STATUS: rdata <= {3'h0, input_invalid, recalibrate_request_busy};
            `DPOM_ADDR_FREQ1: rdata <= sel_meas.measured_frequency[23:16];
            `DPOM_ADDR_FREQ2: rdata <= measured_frequency_snap_q[15:8];
            `DPOM_ADDR_FREQ3: rdata <= measured_frequency_snap_q[7:0];
            `DPOM_ADDR_PHASE1: rdata <= phase_avg_q[15:8];
            `DPOM_ADDR_PHASE2: rdata <= phase_snap_q[7:0];
            default: rdata <= `DPOM_RESET_BYTE;
         endcase
      end else begin
         rdata <= `DPOM_RESET_BYTE;
      end
   end

   // assertions
   recalibrate_request_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
      state_q == DPOM_IDLE && recalibrate_request_req |=> mini_holdover)
      else $error("recalibrate_request did not enter holdover");
   divrst_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
      divider_reset |-> feedback_offset == 17'sd0)
      else $error("dividers reset with nonzero offset");
   ramp_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !ramp_tick |=> $stable(feedback_offset))
      else $error("offset stepped without tick");
   offset_range_a: assert property (@(posedge mclk) disable iff (sys_rst)
      feedback_offset <= `DPOM_OFFSET_MAX_CODE &&
      feedback_offset >= -`DPOM_OFFSET_MAX_CODE)
      else $error("offset out of range");
   exit_target_a: assert property (@(posedge mclk) disable iff (sys_rst)
      state_q == DPOM_EXIT |-> $past(feedback_offset) == $past(target))
      else $error("recalibrate_request left before reaching target");
   compare_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reference_compare_enable |-> aux_path_disable && main_copy_enable)
      else $error("compare mode not routed");
   copy_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
      aux_lock_mode != DPOM_DIRECT && main_lock_mode == DPOM_DIVIDE_BY_N_LOCK
      |-> main_copy_mode == DPOM_DIVIDE_BY_N_LOCK)
      else $error("copy mode wrong");
   bw_range_a: assert property (@(posedge mclk) disable iff (sys_rst)
      main_bw_sel < `DPOM_MAIN_BW_COUNT && aux_bw_sel < `DPOM_AUX_BW_COUNT)
      else $error("bandwidth setting illegal");
   snap_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(rd_stb && addr == `DPOM_ADDR_FREQ1) |=> $stable(measured_frequency_snap_q))
      else $error("frequency snapshot moved");
   recalibrate_request_c: cover property (@(posedge mclk) disable iff (sys_rst)
      state_q == DPOM_EXIT);
   retarget_c: cover property (@(posedge mclk) disable iff (sys_rst)
      state_q == DPOM_RAMPN && wr_stb && addr == `DPOM_ADDR_OFFSET_LO);
   compare_c: cover property (@(posedge mclk) disable iff (sys_rst)
      reference_compare_enable && main_copy_mode == DPOM_LOCK_AT_EIGHT_KHZ);
endmodule

// ===== dpom_top_tb.sv
`timescale 1ns/1ps
`include "dpom_consts.svh"
module dpom_top_tb
   import dpom_pkg::*;
;
   typedef struct packed {
      logic [7:0] mc;
      logic [1:0] aux_m;
      logic [1:0] main_m;
      logic [1:0] copy;
      logic en;
   } dpom_row_type;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic tick_en = 1'b0;
   logic [1:0] main_lock_mode = 2'h0;
   logic [1:0] aux_lock_mode = 2'h0;
   logic [3:0] input_measured_frequency_err = 4'h0;
   logic [3:0] input_measured_frequency_limit = 4'h0;
   logic [7:0] rdata, rv;
   logic ramp_tick, meas_valid, mini_holdover, divider_reset, recalibrate_request_busy;
   logic aux_path_disable, main_copy_enable;
   dpom_meas_type main_meas, aux_meas;
   logic signed [16:0] feedback_offset;
   logic [15:0] ph;
   logic [3:0] aux_reference_force, input_invalid;
   logic [1:0] main_copy_mode, aux_bw_sel;
   logic [4:0] main_bw_sel;
   int err_total = 0;
   int checked = 0;
   int n;
   dpom_row_type rows [5];

   always #20 mclk = ~mclk;

   dpom_meas_model partner (.mclk, .sys_rst, .tick_en, .ramp_tick,
      .meas_valid, .main_meas, .aux_meas);
   dpom_top dut (.mclk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
      .ramp_tick, .meas_valid, .main_meas, .aux_meas, .main_lock_mode,
      .aux_lock_mode, .input_measured_frequency_err, .input_measured_frequency_limit, .feedback_offset,
      .mini_holdover, .divider_reset, .recalibrate_request_busy, .aux_path_disable,
      .aux_reference_force, .main_copy_mode, .main_copy_enable, .main_bw_sel,
      .aux_bw_sel, .input_invalid);

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] e,
                      input logic [23:0] s);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tmo(input int lim);
      if (n >= lim) begin
         err_total++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      @(negedge mclk);
      rv = rdata;
      @(posedge mclk);
   endtask
   task automatic settle(input logic signed [16:0] e);
      logic signed [16:0] p;
      p = feedback_offset;
      for (n = 0; n < 40000 && feedback_offset !== e; n++) begin
         @(negedge mclk);
         chk("offset step", 24'h1, 24'((feedback_offset - p) * (feedback_offset - p) <= 1));
         p = feedback_offset;
      end
      tmo(40000);
      chk("offset", 24'(e), 24'(feedback_offset));
      @(posedge mclk);
   endtask

   initial begin
      rows[0] = '{8'h06, DPOM_LOCK_AT_EIGHT_KHZ, DPOM_DIRECT, DPOM_LOCK_AT_EIGHT_KHZ, 1'b1};
      rows[1] = '{8'h0A, DPOM_DIVIDE_BY_N_LOCK, DPOM_LOCK_AT_EIGHT_KHZ, DPOM_LOCK_AT_EIGHT_KHZ, 1'b1};
      rows[2] = '{8'h3E, DPOM_LOCK_AT_EIGHT_KHZ, DPOM_DIVIDE_BY_N_LOCK, DPOM_DIVIDE_BY_N_LOCK, 1'b1};
      rows[3] = '{8'h22, DPOM_DIRECT, DPOM_DIVIDE_BY_N_LOCK, DPOM_DIRECT, 1'b1};
      rows[4] = '{8'h14, DPOM_DIVIDE_BY_N_LOCK, DPOM_DIVIDE_BY_N_LOCK, DPOM_DIRECT, 1'b0};
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      tick_en <= 1'b1;
      @(posedge mclk);
      chk("reset offset", 24'h0, 24'(feedback_offset));
      chk("reset holdover", 24'h0, 24'(mini_holdover));
      rd(8'hFF);
      chk("unmapped read", 24'h0, 24'(rv));
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         aux_lock_mode <= rows[i].aux_m;
         main_lock_mode <= rows[i].main_m;
         wr(`DPOM_ADDR_MEAS_CTRL, rows[i].mc);
         chk("force", 24'(rows[i].mc[5:2]), 24'(aux_reference_force));
         chk("aux disable", 24'(rows[i].en), 24'(aux_path_disable));
         chk("copy enable", 24'(rows[i].en), 24'(main_copy_enable));
         if (rows[i].en) begin
            chk("copy mode", 24'(rows[i].copy), 24'(main_copy_mode));
         end
      end
      wr(`DPOM_ADDR_MEAS_CTRL, 8'h00);
      $display("test mode table done");
      repeat (600) @(posedge mclk);
      rd(`DPOM_ADDR_FREQ1);
      chk("main measured_frequency hi", 24'h01, 24'(rv));
      wr(`DPOM_ADDR_MEAS_CTRL, 8'h01);
      rd(`DPOM_ADDR_FREQ2);
      chk("snapshot mid", 24'h23, 24'(rv));
      rd(`DPOM_ADDR_FREQ3);
      chk("snapshot lo", 24'h45, 24'(rv));
      rd(`DPOM_ADDR_FREQ1);
      chk("aux measured_frequency hi", 24'hFE, 24'(rv));
      rd(`DPOM_ADDR_FREQ3);
      chk("aux measured_frequency lo", 24'hBA, 24'(rv));
      wr(`DPOM_ADDR_MEAS_CTRL, 8'h00);
      repeat (400) @(posedge mclk);
      rd(`DPOM_ADDR_PHASE1);
      ph[15:8] = rv;
      rd(`DPOM_ADDR_PHASE2);
      ph[7:0] = rv;
      chk("main phase", 24'h1, 24'(ph >= 16'd1008 && ph <= 16'd1024));
      $display("test measure done");
      wr(`DPOM_ADDR_OFFSET_LO, 8'h64);
      wr(`DPOM_ADDR_OFFSET_HI, 8'h00);
      settle(16'sd100);
      wr(`DPOM_ADDR_OFFSET_LO, 8'hFF);
      wr(`DPOM_ADDR_OFFSET_HI, 8'hFF);
      settle(`DPOM_OFFSET_MAX_CODE);
      wr(`DPOM_ADDR_CTRL, 8'h01);
      settle(16'sd0);
      wr(`DPOM_ADDR_OFFSET_LO, 8'h06);
      wr(`DPOM_ADDR_OFFSET_HI, 8'h00);
      chk("offset held", 24'h0, 24'(feedback_offset));
      wr(`DPOM_ADDR_CTRL, 8'h00);
      settle(16'sd6);
      $display("test offset done");
      wr(`DPOM_ADDR_CTRL, 8'h04);
      for (n = 0; n < 200 && divider_reset !== 1'b1; n++) begin
         @(negedge mclk);
         chk("holdover", 24'h1, 24'(mini_holdover));
      end
      tmo(200);
      chk("offset at divider reset", 24'h0, 24'(feedback_offset));
      for (n = 0; n < 50 && divider_reset === 1'b1; n++) begin
         @(negedge mclk);
      end
      chk("divider reset cycles", 24'(`DPOM_DIVRST_CYC), 24'(n));
      @(posedge mclk);
      wr(`DPOM_ADDR_OFFSET_LO, 8'hFD);
      wr(`DPOM_ADDR_OFFSET_HI, 8'hFF);
      wr(`DPOM_ADDR_OFFSET_TOP, 8'h01);
      for (n = 0; n < 200 && recalibrate_request_busy === 1'b1; n++) begin
         @(negedge mclk);
      end
      tmo(200);
      chk("recalibrate_request target", 24'(-17'sd3), 24'(feedback_offset));
      chk("holdover left", 24'h0, 24'(mini_holdover));
      $display("test recalibration done");
      @(posedge mclk);
      input_measured_frequency_err <= 4'hB;
      input_measured_frequency_limit <= 4'h6;
      rd(`DPOM_ADDR_STATUS);
      chk("status", 24'h04, 24'(rv));
      chk("invalid", 24'h2, 24'(input_invalid));
      wr(`DPOM_ADDR_BW, 8'h51);
      chk("main bw", 24'd17, 24'(main_bw_sel));
      chk("aux bw", 24'd2, 24'(aux_bw_sel));
      wr(`DPOM_ADDR_BW, 8'h72);
      chk("main bw kept", 24'd17, 24'(main_bw_sel));
      chk("aux bw kept", 24'd2, 24'(aux_bw_sel));
      sys_rst <= 1'b1;
      @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      chk("second reset bw", 24'h0, 24'(main_bw_sel));
      chk("second reset offset", 24'h0, 24'(feedback_offset));
      $display("test registers done");
      end_sim();
   end
endmodule
